// [common/ccl_pkg.sv]
// package: register map, field layout and types of the comparator control
package ccl_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [3:0]  CCL_CTRL_OFS  = 4'h0;
   localparam logic [31:0] CCL_CTRL_RST  = 32'h0000_00C3;
   localparam logic [31:0] CCL_IMPL_MASK = 32'h0000_E1D3;
   localparam logic [31:0] CCL_WR_MASK   = 32'h0000_E0D3;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int CCL_ON_BIT   = 15;
   localparam int CCL_DRV_BIT  = 14;
   localparam int CCL_INV_BIT  = 13;
   localparam int CCL_STAT_BIT = 8;
   localparam int CCL_EDGE_LSB = 6;
   localparam int CCL_POS_BIT  = 4;
   localparam int CCL_NEG_LSB  = 0;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      CCL_EDGE_NONE = 2'b00,
      CCL_EDGE_RISE = 2'b01,
      CCL_EDGE_FALL = 2'b10,
      CCL_EDGE_BOTH = 2'b11
   } ccl_edge_e;

   typedef enum logic [1:0]
   {
      CCL_NEG_PIN_B = 2'b00,
      CCL_NEG_PIN_C = 2'b01,
      CCL_NEG_PIN_D = 2'b10,
      CCL_NEG_BAND  = 2'b11
   } ccl_neg_e;

   typedef struct packed
   {
      logic      on;
      logic      drive_en;
      logic      invert;
      ccl_edge_e edge_sel;
      logic      pos_sel;
      ccl_neg_e  neg_sel;
   } ccl_ctrl_s;

   typedef struct packed
   {
      logic     enable;
      logic     pos_sel;
      ccl_neg_e neg_sel;
   } ccl_analog_s;

   localparam ccl_ctrl_s CCL_CTRL_INIT = '{1'b0, 1'b0, 1'b0,
      CCL_EDGE_BOTH, 1'b0, CCL_NEG_BAND};

endpackage

// [src/ccl_sync.sv]
// two-flop synchroniser for the asynchronous comparator result
`timescale 1ns/1ns
module ccl_sync
   import ccl_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_q;

   // first stage feeds the second stage only
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// [src/ccl_edge.sv]
// edge detector that turns result transitions into one-cycle requests
`timescale 1ns/1ns
module ccl_edge
   import ccl_pkg::*;
(
   input  wire logic      mclk,
   input  wire logic      rst,
   input  wire logic      arm,
   input  wire logic      level,
   input  ccl_edge_e      edge_sel,
   output logic           irq_pulse
);

   logic prev_q;
   logic rise;
   logic fall;

   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         prev_q <= 1'b0;
      else
         prev_q <= level;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         irq_pulse <= 1'b0;
      else
         irq_pulse <= arm & ((rise & edge_sel[0]) | (fall & edge_sel[1]));
   end

   property p_edge_rise;
      @(posedge mclk) disable iff (rst)
      (arm && rise && edge_sel[0]) |=> irq_pulse;
   endproperty
   a_edge_rise: assert property (p_edge_rise)
      else $error("rising edge selected but no request");

   property p_edge_none;
      @(posedge mclk) disable iff (rst)
      (edge_sel == CCL_EDGE_NONE) |=> !irq_pulse;
   endproperty
   a_edge_none: assert property (p_edge_none)
      else $error("request raised with events disabled");

   property p_edge_cause;
      @(posedge mclk) disable iff (rst)
      irq_pulse |-> $past(level != prev_q) && $past(arm);
   endproperty
   a_edge_cause: assert property (p_edge_cause)
      else $error("request without a qualifying edge");

endmodule

// [src/ccl_top.sv]
// comparator control word, result conditioning and event generation
`timescale 1ns/1ns
// Operation
// - bit 15 enables the module; writing it leaves other fields as written.
// - disabling keeps every other stored setting for the next enable.
// - bit 14 drives the conditioned result onto the result pin while bit 15 is set.
// - bit 13 inverts the comparator result.
// - inversion also feeds the edge detector, flipping the event edge.
// - bit 8 reads back the present result, read only.
// - bits 7-6 pick events: both, falling, rising or none.
// - bit 4 picks internal reference or positive pin for plus input.
// - bits 1-0 pick band reference, pin D, pin C or pin B for minus.
// - unused bits read zero and ignore writes.
module ccl_top
   import ccl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        comp_result_raw,
   output ccl_analog_s      analog_ctrl,
   output logic             result_output_pin,
   output logic             result_output_pin_oe,
   output logic             irq_pulse
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] ctrl_to_word(input ccl_ctrl_s c,
                                                input logic res);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CCL_ON_BIT]                 = c.on;
      w[CCL_DRV_BIT]                = c.drive_en;
      w[CCL_INV_BIT]                = c.invert;
      w[CCL_STAT_BIT]               = res;
      w[CCL_EDGE_LSB+1:CCL_EDGE_LSB] = c.edge_sel;
      w[CCL_POS_BIT]                = c.pos_sel;
      w[CCL_NEG_LSB+1:CCL_NEG_LSB]  = c.neg_sel;
      return w;
   endfunction

   function automatic ccl_ctrl_s word_to_ctrl(input logic [31:0] w);
      ccl_ctrl_s c;
      c.on       = w[CCL_ON_BIT];
      c.drive_en = w[CCL_DRV_BIT];
      c.invert   = w[CCL_INV_BIT];
      c.edge_sel = ccl_edge_e'(w[CCL_EDGE_LSB+1:CCL_EDGE_LSB]);
      c.pos_sel  = w[CCL_POS_BIT];
      c.neg_sel  = ccl_neg_e'(w[CCL_NEG_LSB+1:CCL_NEG_LSB]);
      return c;
   endfunction

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   typedef enum logic {CCL_BUS_IDLE, CCL_BUS_ACK} ccl_bus_e;

   ccl_bus_e    bus_q;
   ccl_ctrl_s   ctrl_q;
   logic        hit;
   logic        wr_ack;
   logic        rd_ack;
   logic [31:0] lane_mask;
   logic [31:0] merged;
   logic        sync_res;
   logic        cond_d;
   logic        result_q;
   logic [3:0]  on_hist_q;
   logic        arm;

   // ------------------------------------------------------------------
   // avalon slave, one wait state per access
   // ------------------------------------------------------------------
   assign hit    = (avs_address == CCL_CTRL_OFS);
   assign wr_ack = (bus_q == CCL_BUS_ACK) & avs_write;
   assign rd_ack = (bus_q == CCL_BUS_ACK) & avs_read;

   assign avs_waitrequest = (avs_read | avs_write) &
                            (bus_q != CCL_BUS_ACK);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         bus_q <= CCL_BUS_IDLE;
      else
      begin
         case (bus_q)
            CCL_BUS_IDLE:
            begin
               if (avs_read | avs_write)
                  bus_q <= CCL_BUS_ACK;
            end
            CCL_BUS_ACK:
               bus_q <= CCL_BUS_IDLE;
            default:
               bus_q <= CCL_BUS_IDLE;
         endcase
      end
   end

   // read word is captured in the wait cycle so it is a flop at the ack
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else if ((bus_q == CCL_BUS_IDLE) & avs_read)
      begin
         if (hit)
            avs_readdata <= ctrl_to_word(ctrl_q, result_q);
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------
   // control word
   // ------------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         lane_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
   end

   // only implemented bits take part; reserved bits are dropped
   assign merged = (ctrl_to_word(ctrl_q, 1'b0) & ~lane_mask) |
                   (avs_writedata & lane_mask & CCL_WR_MASK);

   // the enable is just one field: clearing it keeps the rest intact
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ctrl_q <= CCL_CTRL_INIT;
      else if (wr_ack & hit)
         ctrl_q <= word_to_ctrl(merged);
   end

   assign analog_ctrl.enable  = ctrl_q.on;
   assign analog_ctrl.pos_sel = ctrl_q.pos_sel;
   assign analog_ctrl.neg_sel = ctrl_q.neg_sel;

   // ------------------------------------------------------------------
   // result conditioning
   // ------------------------------------------------------------------
   ccl_sync u_sync
   (
      .mclk     (mclk),
      .rst      (rst),
      .async_in (comp_result_raw),
      .sync_out (sync_res)
   );

   // a disabled core gives no valid result, so it is held low
   assign cond_d = ctrl_q.on & (sync_res ^ ctrl_q.invert);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         result_q <= 1'b0;
      else
         result_q <= cond_d;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         result_output_pin    <= 1'b0;
         result_output_pin_oe <= 1'b0;
      end
      else
      begin
         result_output_pin    <= cond_d;
         result_output_pin_oe <= ctrl_q.on & ctrl_q.drive_en;
      end
   end

   // ------------------------------------------------------------------
   // event generation
   // ------------------------------------------------------------------
   // the synchroniser and the result flop still carry samples taken while
   // the core was off, so edges stay masked until those have drained; the
   // jump from the forced low level never raises a request either
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         on_hist_q <= 4'h0;
      else
         on_hist_q <= {on_hist_q[2:0], ctrl_q.on};
   end

   assign arm = ctrl_q.on & (&on_hist_q);

   ccl_edge u_edge
   (
      .mclk      (mclk),
      .rst       (rst),
      .arm       (arm),
      .level     (result_q),
      .edge_sel  (ctrl_q.edge_sel),
      .irq_pulse (irq_pulse)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_ctrl_write;
      wr_ack && hit;
   endsequence

   sequence s_quiet;
      !wr_ack [*2];
   endsequence

   property p_enable_write;
      s_ctrl_write ##0 avs_byteenable[1]
         |=> ctrl_q.on == $past(avs_writedata[CCL_ON_BIT]);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable bit did not take written value");

   property p_other_fields;
      s_ctrl_write ##0 avs_byteenable[0] |=>
         ctrl_q.pos_sel == $past(avs_writedata[CCL_POS_BIT]) &&
         ctrl_q.edge_sel == $past(avs_writedata[7:6]);
   endproperty
   a_other_fields: assert property (p_other_fields)
      else $error("low byte fields not taken from write");

   property p_hold;
      !(wr_ack && hit) |=> $stable(ctrl_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("control word changed without a write");

   property p_keep_on_disable;
      $fell(ctrl_q.on) && !$past(avs_byteenable[0]) |->
         $stable(ctrl_q.edge_sel) && $stable(ctrl_q.neg_sel);
   endproperty
   a_keep_on_disable: assert property (p_keep_on_disable)
      else $error("disable disturbed stored settings");

   property p_pin_drive;
      ##1 result_output_pin_oe ==
         $past(ctrl_q.on && ctrl_q.drive_en);
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("pin enable does not follow drive field");

   property p_pin_value;
      ctrl_q.on && $stable(ctrl_q) |=>
         result_output_pin == result_q;
   endproperty
   a_pin_value: assert property (p_pin_value)
      else $error("pin value differs from conditioned result");

   property p_invert;
      ctrl_q.on |=> result_q == ($past(sync_res) ^ $past(ctrl_q.invert));
   endproperty
   a_invert: assert property (p_invert)
      else $error("result polarity wrong");

   property p_inverted_event;
      ($fell(sync_res) && arm &&
       $stable(ctrl_q) && ctrl_q.invert &&
       ctrl_q.edge_sel == CCL_EDGE_RISE && !wr_ack)
         |-> ##2 irq_pulse;
   endproperty
   a_inverted_event: assert property (p_inverted_event)
      else $error("inverted falling result gave no request");

   property p_status_read;
      rd_ack && hit |-> avs_readdata[CCL_STAT_BIT] == $past(result_q);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status bit differs from result");

   property p_events_off;
      ctrl_q.edge_sel == CCL_EDGE_NONE ##0 s_quiet |=> !irq_pulse;
   endproperty
   a_events_off: assert property (p_events_off)
      else $error("request while events disabled");

   property p_pos_sel;
      s_ctrl_write ##0 avs_byteenable[0]
         |=> analog_ctrl.pos_sel == $past(avs_writedata[CCL_POS_BIT]);
   endproperty
   a_pos_sel: assert property (p_pos_sel)
      else $error("positive select not applied");

   property p_neg_sel;
      s_ctrl_write ##0 avs_byteenable[0]
         |=> analog_ctrl.neg_sel == $past(avs_writedata[1:0]);
   endproperty
   a_neg_sel: assert property (p_neg_sel)
      else $error("negative select not applied");

   property p_reserved;
      rd_ack |-> (avs_readdata & ~CCL_IMPL_MASK) == 32'h0000_0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits read non zero");

   property p_one_pulse;
      irq_pulse && $stable(result_q) |=> !irq_pulse;
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("request longer than one cycle per edge");

   property p_enable_mask;
      $rose(ctrl_q.on) |-> !irq_pulse [*5];
   endproperty
   a_enable_mask: assert property (p_enable_mask)
      else $error("request from stale samples after enable");

   property p_wait_bound;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_bound: assert property (p_wait_bound)
      else $error("wait state longer than one cycle");

endmodule

// [dv/ccl_comp_model.sv]
// behavioural analog comparator core with its selectable input sources
`timescale 1ns/1ns
module ccl_comp_model
   import ccl_pkg::*;
#(
   parameter logic [7:0] REF_INT  = 8'h32,
   parameter logic [7:0] REF_BAND = 8'h50
)
(
   input  wire logic       mclk,
   input  ccl_analog_s     analog_ctrl,
   input  wire logic [7:0] pos_lvl,
   input  wire logic [7:0] neg_b_lvl,
   input  wire logic [7:0] neg_c_lvl,
   input  wire logic [7:0] neg_d_lvl,
   output logic            comp_result_raw
);
   logic [7:0] plus_lvl;
   logic [7:0] minus_lvl;
   logic       idle_q = 1'b0;

   always_comb plus_lvl = analog_ctrl.pos_sel ? REF_INT : pos_lvl;
   always_comb
   begin
      case (analog_ctrl.neg_sel)
         CCL_NEG_PIN_B: minus_lvl = neg_b_lvl;
         CCL_NEG_PIN_C: minus_lvl = neg_c_lvl;
         CCL_NEG_PIN_D: minus_lvl = neg_d_lvl;
         default:       minus_lvl = REF_BAND;
      endcase
   end
   // an unpowered core gives no trusted level: toggle so any leak shows
   always @(posedge mclk) idle_q <= ~idle_q;
   assign comp_result_raw = analog_ctrl.enable ? (plus_lvl > minus_lvl)
                                               : idle_q;
endmodule

// [dv/test_comparator_control_logic.sv]
// self-checking bench of the comparator control logic
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("Error %0t: got %h exp %h", $time, a, b); end end
module test_comparator_control_logic;
   import ccl_pkg::*;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        comp_result_raw;
   ccl_analog_s analog_ctrl;
   logic        result_output_pin;
   logic        result_output_pin_oe;
   logic        irq_pulse;
   logic [7:0]  pos_lvl = 8'h64;
   logic [31:0] ctrl_exp = 32'h0000_00C3;
   logic [31:0] seed = 32'h0000_0010;
   logic [31:0] exp_q[$];
   logic [31:0] rd_exp;
   logic        irq_prev = 1'b0;
   int          fails = 0;
   int          checked = 0;
   int          irq_cnt = 0;

   always #25 mclk = ~mclk;

   ccl_top dut_u (.mclk(mclk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .comp_result_raw(comp_result_raw), .analog_ctrl(analog_ctrl),
      .result_output_pin(result_output_pin),
      .result_output_pin_oe(result_output_pin_oe), .irq_pulse(irq_pulse));

   ccl_comp_model #(.REF_INT(8'h32), .REF_BAND(8'h50)) core_u (.mclk(mclk),
      .analog_ctrl(analog_ctrl), .pos_lvl(pos_lvl), .neg_b_lvl(8'h28),
      .neg_c_lvl(8'h3C), .neg_d_lvl(8'h78),
      .comp_result_raw(comp_result_raw));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // conditioned result the rules predict from the stored fields
   function automatic logic cond();
      logic [7:0] p;
      logic [7:0] n;
      p = ctrl_exp[4] ? 8'h32 : pos_lvl;
      n = ctrl_exp[1:0] == 2'b00 ? 8'h28 : ctrl_exp[1:0] == 2'b01 ? 8'h3C :
          ctrl_exp[1:0] == 2'b10 ? 8'h78 : 8'h50;
      return ctrl_exp[15] & ((p > n) ^ ctrl_exp[13]);
   endfunction

   task automatic ack_wait();
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         fails++;
         $display("Error %0t: no bus answer", $time);
         stop_test();
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d,
                         input logic [3:0] be);
      logic [31:0] m;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      ack_wait();
      avs_write <= 1'b0;
      for (int i = 0; i < 4; i++) m[8*i +: 8] = {8{be[i]}};
      if (a == 4'h0) ctrl_exp = (ctrl_exp & ~(m & CCL_WR_MASK)) |
                                (d & m & CCL_WR_MASK);
      @(posedge mclk);
   endtask

   task automatic bus_rd(input logic [3:0] a);
      exp_q.push_back(a == 4'h0 ? ctrl_exp | {23'h0, cond(), 8'h00} : 0);
      avs_address <= a;
      avs_read <= 1'b1;
      ack_wait();
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic chk_out();
      `CHK(analog_ctrl, {ctrl_exp[15], ctrl_exp[4], ctrl_exp[1:0]})
      `CHK(result_output_pin_oe, ctrl_exp[15] & ctrl_exp[14])
      `CHK(result_output_pin, cond())
      bus_rd(4'h0);
   endtask

   // three edges from raw to result, so five cycles leave a margin
   task automatic cfg(input logic [31:0] d);
      bus_wr(4'h0, d, 4'hF);
      repeat (5) @(posedge mclk);
      chk_out();
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // monitors
   // ------------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      begin
         rd_exp = exp_q.pop_front();
         `CHK(avs_readdata, rd_exp)
      end
      if (irq_prev === 1'b1)
         `CHK(irq_pulse, 1'b0)
      if (irq_pulse === 1'b1)
         irq_cnt++;
      irq_prev <= irq_pulse;
   end

   initial
   begin
      repeat (5000) @(posedge mclk);
      fails++;
      stop_test();
   end

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk_out();
      bus_wr(4'h4, 32'hFFFF_FFFF, 4'hF);
      bus_rd(4'h8);
      $display("test reset and unmapped done");
      repeat (8)
      begin
         bus_wr(4'h0, xs(), 4'(xs()));
         repeat (5) @(posedge mclk);
         chk_out();
      end
      $display("test random writes done");
      for (int k = 0; k < 8; k++)
         cfg(32'h0000_8000 | (k[2] << 4) | k[1:0]);
      $display("test routing done");
      cfg(32'h0000_E0D2);
      bus_wr(4'h0, 32'h0000_6000, 4'b0010);
      @(posedge mclk);
      chk_out();
      cfg(32'h0000_E0D2);
      $display("test disable keeps fields done");
      for (int k = 0; k < 8; k++)
      begin
         pos_lvl <= 8'h00;
         cfg(32'h0000_C000 | (k[2] << 13) | (k[1:0] << 6));
         irq_cnt = 0;
         pos_lvl <= 8'h64;
         repeat (8) @(posedge mclk);
         `CHK(irq_cnt, int'(k[2] ? k[1] : k[0]))
         irq_cnt = 0;
         pos_lvl <= 8'h00;
         repeat (8) @(posedge mclk);
         `CHK(irq_cnt, int'(k[2] ? k[0] : k[1]))
      end
      $display("test events done");
      cfg(32'h0000_40C0);
      irq_cnt = 0;
      pos_lvl <= 8'h64;
      repeat (20) @(posedge mclk);
      `CHK(irq_cnt, 0)
      chk_out();
      $display("test disabled core done");
      stop_test();
   end
endmodule
